// ===== rtl/esa_clk_div.sv
// Converter clock generator: divides the port clock by a floored ratio
`timescale 1ns/10ps
module esa_clk_div
  import esa_pkg::*;
#(
  parameter int DIV_W = 8
)(
  input  wire logic clk,
  input  wire logic rst_n,
  esa_div_if.gen    div
);

  logic [DIV_W-1:0] cnt_ff;
  logic [DIV_W-1:0] eff_ratio;
  logic             tick_ff;
  logic             level_ff;

  // Ratios below the floor are raised to it, never honoured
  assign eff_ratio = (div.ratio < MIN_DIV) ? MIN_DIV : div.ratio;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_ff   <= '0;
      tick_ff  <= 1'b0;
      level_ff <= 1'b0;
    end
    else
    begin
      tick_ff <= (cnt_ff == DIV_W'(eff_ratio - 8'h01));
      if (cnt_ff >= DIV_W'(eff_ratio - 8'h01))
        cnt_ff <= '0;
      else
        cnt_ff <= DIV_W'(cnt_ff + 1'b1);
      level_ff <= (cnt_ff < DIV_W'(eff_ratio >> 1));
    end
  end

  assign div.tick  = tick_ff;
  assign div.level = level_ff;

endmodule : esa_clk_div

// ===== rtl/esa_ctrl.sv
// Event-sampling converter control: trigger, busy, results and port
//
// Function
// - Trigger rising edge marks the sampling instant
// - Busy rises on next port clock edge
// - Asynchronous trigger resynchronised to converter clock (here pins taken as synchronous to clk, no synchroniser)
// - No triggered sampling while sequencer enabled
// - Port clock must run during triggered operation
// - Extra settle bit ignored in triggered mode
// - Both trigger inputs are ORed together
// - Conversion starts on next converter clock edge
// - Triggers ignored, no abort, while busy
// - Settings latched when busy falls
// - Result and end pulse ten cycles later
// - Averaged channel reports only final sample
// - End, sequence and channel outputs as continuous
// - First result follows first trigger after reset (here reset leaves event mode off, so conversions run free)
// - Converter clock ratio at least eight
// - Port write stored three cycles later, done
// - Port read data valid three cycles later
// - Converter clock divided from port clock
// - Conversion lasts twenty-two converter clocks
// - Channel output updated when busy falls
// - Sequence end pulses on last channel
//
// The placing of the registers and the plain strobed port were decided locally.
`timescale 1ns/10ps
module esa_ctrl
  import esa_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        trigger_level_input,
  input  wire logic        trigger_clocked_input,
  input  wire logic [9:0]  conv_code,
  input  wire logic        port_access_enable,
  input  wire logic        port_write_enable,
  input  wire logic [6:0]  port_addr_bus,
  input  wire logic [15:0] port_write_bus,
  output logic      [15:0] port_read_bus,
  output logic             port_access_done,
  output logic             busy,
  output logic             conv_done_pulse,
  output logic             sequence_done_pulse,
  output logic      [4:0]  channel
);

  function automatic logic [4:0] esa_next_chan(input logic [15:0] mask,
                                               input logic [4:0]  cur);
    logic [4:0] pick;
    logic [3:0] idx;
    pick = cur;
    // Descending scan so the nearest following channel wins
    for (int i = 16; i >= 1; i--)
    begin
      idx = 4'(cur[3:0] + 4'(i));
      if (mask[idx])
        pick = {1'b0, idx};
    end
    return pick;
  endfunction : esa_next_chan

  function automatic logic [4:0] esa_last_chan(input logic [15:0] mask);
    logic [4:0] pick;
    pick = 5'h00;
    for (int i = 0; i < 16; i++)
    begin
      if (mask[i])
        pick = 5'(i);
    end
    return pick;
  endfunction : esa_last_chan

  // Reset release synchroniser
  logic             rst_meta_ff;
  logic             rst_n;

  // Trigger path
  logic             trig_now;
  logic             trig_prev_ff;
  logic             trig_rise;

  // Written and active configuration
  logic [15:0]      cfg0_ff;
  logic [15:0]      cfg1_ff;
  logic [15:0]      cfg2_ff;
  logic [15:0]      seq_mask_ff;
  logic [15:0]      act_cfg0_ff;
  logic [15:0]      act_cfg1_ff;
  logic [15:0]      act_cfg2_ff;
  logic [15:0]      act_mask_ff;
  logic             event_mode;
  logic             seq_on;
  logic [3:0]       acq_len;
  logic [4:0]       cur_chan;

  // Conversion sequencing
  esa_state_t       state_ff;
  logic [3:0]       acq_cnt_ff;
  logic [4:0]       tick_cnt_ff;
  logic             busy_ff;
  logic             conv_end;
  logic [4:0]       conv_chan_ff;
  logic [4:0]       seq_chan_ff;
  logic [4:0]       channel_ff;

  // Result transfer and averaging
  logic [3:0]       eoc_cnt_ff;
  logic [9:0]       held_code_ff;
  logic             held_last_ff;
  logic [17:0]      acc_sum_ff;
  logic [8:0]       acc_cnt_ff;
  logic [4:0]       acc_chan_ff;
  logic             eoc_ff;
  logic             eos_ff;
  logic [15:0]      result_mem [32];
  logic [31:0]      res_valid_ff;
  logic [17:0]      sum_new;
  logic [8:0]       cnt_new;
  logic [8:0]       avg_need;
  logic [3:0]       avg_shift;
  logic [9:0]       avg_code;

  // Reconfiguration port
  logic [1:0]       port_cnt_ff;
  logic             port_we_ff;
  logic [6:0]       port_addr_ff;
  logic [15:0]      port_data_ff;
  logic             port_done_ff;
  logic [15:0]      port_rdata_ff;
  logic [15:0]      read_mux;

  esa_div_if        div_link ();

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rst_meta_ff <= 1'b0;
      rst_n       <= 1'b0;
    end
    else
    begin
      rst_meta_ff <= 1'b1;
      rst_n       <= rst_meta_ff;
    end
  end

  esa_clk_div #(
    .DIV_W (8)
  ) u_div (
    .clk   (clk), // No fallback oscillator: timing stops with clk
    .rst_n (rst_n),
    .div   (div_link.gen)
  );

  assign div_link.ratio = act_cfg2_ff[CFG2_DIV_LSB +: 8];

  // Pins taken as synchronous to clk: no synchroniser delay, so busy
  // rises on the first edge after the trigger edge
  assign trig_now = trigger_level_input | trigger_clocked_input;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      trig_prev_ff <= 1'b0;
    else
      trig_prev_ff <= trig_now;
  end

  assign trig_rise = trig_now & ~trig_prev_ff & ~busy_ff;

  // Sequencer overrides the trigger: the two never run together
  assign seq_on     = (act_cfg1_ff[CFG1_SEQ_LSB +: 2] != 2'b00);
  assign event_mode = act_cfg0_ff[CFG0_EVENT_BIT] & ~seq_on;
  assign acq_len    = act_cfg0_ff[CFG0_SETTLE_BIT] ? 4'(ACQ_TICKS + SETTLE_TICKS) : ACQ_TICKS;
  assign cur_chan   = seq_on ? seq_chan_ff : act_cfg0_ff[CFG0_CHAN_LSB +: 5];
  assign conv_end   = (state_ff == ST_CONV) && div_link.tick
                      && (tick_cnt_ff == 5'(CONV_TICKS - 5'h01));

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_ff     <= ST_ACQ;
      acq_cnt_ff   <= '0;
      tick_cnt_ff  <= '0;
      busy_ff      <= 1'b0;
      conv_chan_ff <= '0;
    end
    else
    begin
      case (state_ff)
        ST_ACQ:
        begin
          if (event_mode)
          begin
            // Acquisition length is set by the trigger alone here
            acq_cnt_ff <= '0;
            if (trig_rise)
            begin
              state_ff     <= ST_WAIT_TICK;
              busy_ff      <= 1'b1;
              conv_chan_ff <= cur_chan;
            end
          end
          else if (div_link.tick)
          begin
            if (acq_cnt_ff >= 4'(acq_len - 4'h1))
            begin
              acq_cnt_ff   <= '0;
              state_ff     <= ST_CONV;
              tick_cnt_ff  <= '0;
              busy_ff      <= 1'b1;
              conv_chan_ff <= cur_chan;
            end
            else
              acq_cnt_ff <= 4'(acq_cnt_ff + 4'h1);
          end
        end
        ST_WAIT_TICK:
        begin
          if (div_link.tick)
          begin
            state_ff    <= ST_CONV;
            tick_cnt_ff <= '0;
          end
        end
        ST_CONV:
        begin
          // No abort path: only the full count ends a conversion
          if (conv_end)
          begin
            state_ff <= ST_ACQ;
            busy_ff  <= 1'b0;
          end
          else if (div_link.tick)
            tick_cnt_ff <= 5'(tick_cnt_ff + 5'h01);
        end
        default:
        begin
          state_ff <= ST_ACQ;
          busy_ff  <= 1'b0;
        end
      endcase
    end
  end

  // Settings written during a conversion apply from its end onward
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      act_cfg0_ff <= CFG0_RST;
      act_cfg1_ff <= CFG1_RST;
      act_cfg2_ff <= CFG2_RST;
      act_mask_ff <= SEQ_MASK_RST;
    end
    else if (conv_end)
    begin
      act_cfg0_ff <= cfg0_ff;
      act_cfg1_ff <= cfg1_ff;
      act_cfg2_ff <= cfg2_ff;
      act_mask_ff <= seq_mask_ff;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      channel_ff  <= '0;
      seq_chan_ff <= '0;
    end
    else if (conv_end)
    begin
      channel_ff  <= conv_chan_ff;
      seq_chan_ff <= esa_next_chan(seq_mask_ff, conv_chan_ff);
    end
  end

  always_comb
  begin
    case (act_cfg0_ff[CFG0_AVG_LSB +: 2])
      2'b01:   begin avg_need = 9'h010; avg_shift = 4'h4; end
      2'b10:   begin avg_need = 9'h040; avg_shift = 4'h6; end
      2'b11:   begin avg_need = 9'h100; avg_shift = 4'h8; end
      default: begin avg_need = 9'h001; avg_shift = 4'h0; end
    endcase
  end

  // A channel change restarts the averaging set
  assign sum_new  = (acc_chan_ff == channel_ff) ? 18'(acc_sum_ff + {8'h00, held_code_ff})
                                                : {8'h00, held_code_ff};
  assign cnt_new  = (acc_chan_ff == channel_ff) ? 9'(acc_cnt_ff + 9'h001) : 9'h001;
  assign avg_code = 10'(sum_new >> avg_shift);

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      eoc_cnt_ff   <= '0;
      held_code_ff <= '0;
      held_last_ff <= 1'b0;
      acc_sum_ff   <= '0;
      acc_cnt_ff   <= '0;
      acc_chan_ff  <= '0;
      eoc_ff       <= 1'b0;
      eos_ff       <= 1'b0;
    end
    else
    begin
      eoc_ff <= 1'b0;
      eos_ff <= 1'b0;
      if (conv_end)
      begin
        eoc_cnt_ff   <= EOC_DELAY;
        held_code_ff <= conv_code;
        held_last_ff <= seq_on && (conv_chan_ff == esa_last_chan(act_mask_ff));
      end
      else if (eoc_cnt_ff != 4'h0)
      begin
        eoc_cnt_ff <= 4'(eoc_cnt_ff - 4'h1);
        if (eoc_cnt_ff == 4'h1)
        begin
          acc_chan_ff <= channel_ff;
          if (cnt_new >= avg_need)
          begin
            acc_sum_ff <= '0;
            acc_cnt_ff <= '0;
            eoc_ff     <= 1'b1;
            eos_ff     <= held_last_ff;
          end
          else
          begin
            acc_sum_ff <= sum_new;
            acc_cnt_ff <= cnt_new;
          end
        end
      end
    end
  end

  // Result store: array without reset, written only on a completed set
  always_ff @(posedge clk)
  begin
    if ((eoc_cnt_ff == 4'h1) && !conv_end && (cnt_new >= avg_need))
      result_mem[channel_ff] <= {avg_code, 6'h00};
  end

  // Unwritten result slots read as zero rather than unknown
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      res_valid_ff <= '0;
    else if ((eoc_cnt_ff == 4'h1) && !conv_end && (cnt_new >= avg_need))
      res_valid_ff[channel_ff] <= 1'b1;
  end

  always_comb
  begin
    if (port_addr_ff <= ADDR_RESULT_LAST)
      read_mux = res_valid_ff[port_addr_ff[4:0]] ? result_mem[port_addr_ff[4:0]] : 16'h0000;
    else if (port_addr_ff == ADDR_CFG0)
      read_mux = cfg0_ff;
    else if (port_addr_ff == ADDR_CFG1)
      read_mux = cfg1_ff;
    else if (port_addr_ff == ADDR_CFG2)
      read_mux = cfg2_ff;
    else if (port_addr_ff == ADDR_SEQ_MASK)
      read_mux = seq_mask_ff;
    else
      read_mux = 16'h0000;
  end

  // Enables arriving while an access is in flight are dropped
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      port_cnt_ff   <= '0;
      port_we_ff    <= 1'b0;
      port_addr_ff  <= '0;
      port_data_ff  <= '0;
      port_done_ff  <= 1'b0;
      port_rdata_ff <= '0;
    end
    else
    begin
      port_done_ff <= 1'b0;
      if ((port_cnt_ff == 2'h0) && port_access_enable)
      begin
        port_cnt_ff  <= PORT_LATENCY;
        port_we_ff   <= port_write_enable;
        port_addr_ff <= port_addr_bus;
        port_data_ff <= port_write_bus;
      end
      else if (port_cnt_ff != 2'h0)
      begin
        port_cnt_ff <= 2'(port_cnt_ff - 2'h1);
        if (port_cnt_ff == 2'h1)
        begin
          port_done_ff <= 1'b1;
          if (!port_we_ff)
            port_rdata_ff <= read_mux;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cfg0_ff     <= CFG0_RST;
      cfg1_ff     <= CFG1_RST;
      cfg2_ff     <= CFG2_RST;
      seq_mask_ff <= SEQ_MASK_RST;
    end
    else if ((port_cnt_ff == 2'h1) && port_we_ff)
    begin
      if (port_addr_ff == ADDR_CFG0)
        cfg0_ff <= port_data_ff;
      else if (port_addr_ff == ADDR_CFG1)
        cfg1_ff <= port_data_ff;
      else if (port_addr_ff == ADDR_CFG2)
        cfg2_ff <= port_data_ff;
      else if (port_addr_ff == ADDR_SEQ_MASK)
        seq_mask_ff <= port_data_ff;
    end
  end

  assign port_read_bus       = port_rdata_ff;
  assign port_access_done    = port_done_ff;
  assign busy                = busy_ff;
  assign conv_done_pulse     = eoc_ff;
  assign sequence_done_pulse = eos_ff;
  assign channel             = channel_ff;

endmodule : esa_ctrl

// ===== rtl/esa_div_if.sv
// Converter clock divider link between control and divider
`timescale 1ns/10ps
interface esa_div_if;
  logic [7:0] ratio;
  logic       tick;
  logic       level;

  modport ctl (output ratio, input tick, input level);
  modport gen (input ratio, output tick, output level);
endinterface : esa_div_if

// ===== rtl/esa_pkg.sv
// Shared constants and types for the event-sampling converter control block
package esa_pkg;

  // Register addresses on the reconfiguration port
  localparam logic [6:0]  ADDR_RESULT_LAST = 7'h1F;
  localparam logic [6:0]  ADDR_CFG0        = 7'h40;
  localparam logic [6:0]  ADDR_CFG1        = 7'h41;
  localparam logic [6:0]  ADDR_CFG2        = 7'h42;
  localparam logic [6:0]  ADDR_SEQ_MASK    = 7'h48;

  // Field positions
  localparam int          CFG0_CHAN_LSB    = 0;
  localparam int          CFG0_SETTLE_BIT  = 8;
  localparam int          CFG0_EVENT_BIT   = 9;
  localparam int          CFG0_AVG_LSB     = 12;
  localparam int          CFG1_SEQ_LSB     = 12;
  localparam int          CFG2_DIV_LSB     = 8;
  localparam int          RESULT_LSB       = 6;

  // Reset values
  localparam logic [15:0] CFG0_RST         = 16'h0000;
  localparam logic [15:0] CFG1_RST         = 16'h0000;
  localparam logic [15:0] CFG2_RST         = 16'h0800;
  localparam logic [15:0] SEQ_MASK_RST     = 16'h0001;

  // Timing counts
  localparam logic [4:0]  CONV_TICKS       = 5'h16;
  localparam logic [3:0]  EOC_DELAY        = 4'hA;
  localparam logic [1:0]  PORT_LATENCY     = 2'h3;
  localparam logic [3:0]  ACQ_TICKS        = 4'h4;
  localparam logic [3:0]  SETTLE_TICKS     = 4'h6;
  localparam logic [7:0]  MIN_DIV          = 8'h08;

  typedef enum logic [1:0] {
    ST_ACQ,
    ST_WAIT_TICK,
    ST_CONV
  } esa_state_t;

endpackage : esa_pkg

// ===== sim/esa_ctrl_chk.sv
// Port and conversion timing assertions for the event-sampling control block
`timescale 1ns/10ps
module esa_ctrl_chk
(
  input wire logic       clk,
  input wire logic       rst_b,
  input wire logic       port_access_enable,
  input wire logic       port_access_done,
  input wire logic       busy,
  input wire logic       conv_done_pulse,
  input wire logic       sequence_done_pulse,
  input wire logic [4:0] channel
);
  int unsigned busy_cnt_ff;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  // Busy length in port clocks, read at the fall
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
      busy_cnt_ff <= 0;
    else
      busy_cnt_ff <= busy ? busy_cnt_ff + 1 : 0;

  sequence s_port_wait;
    !port_access_done [*3];
  endsequence

  sequence s_busy_end;
    busy ##1 !busy;
  endsequence

  port_lat_a: assert property (port_access_enable |=> s_port_wait ##1 port_access_done)
    else $error("port access done not three cycles after enable");
  done_cause_a: assert property (port_access_done |-> $past(port_access_enable, 4))
    else $error("port access done without a request");
  done_pulse_a: assert property (port_access_done |=> !port_access_done)
    else $error("port access done longer than one cycle");
  eoc_delay_a: assert property (conv_done_pulse |-> $past(busy, 11) && !$past(busy, 10))
    else $error("end of conversion not ten cycles after busy fall");
  eoc_pulse_a: assert property (conv_done_pulse |=> !conv_done_pulse)
    else $error("end of conversion longer than one cycle");
  eos_with_eoc_a: assert property (sequence_done_pulse |-> conv_done_pulse)
    else $error("end of sequence apart from end of conversion");
  chan_hold_a: assert property (!$stable(channel) |-> $fell(busy))
    else $error("channel changed away from busy fall");
  busy_len_a: assert property (s_busy_end |-> busy_cnt_ff inside {[170:186]})
    else $error("conversion length not twenty-two converter clocks");
endmodule : esa_ctrl_chk

// ===== sim/esa_ctrl_tb.sv
// Self-checking bench for the event-sampling converter control block
`timescale 1ns/10ps
module esa_ctrl_tb;
  import esa_pkg::*;
  typedef struct packed {logic w; logic [6:0] a; logic [15:0] d; logic [15:0] e;} esa_row_t;

  logic        clk;
  logic        rst_b;
  logic        fire;
  logic        sel;
  logic [9:0]  code;
  logic        trigger_level_input;
  logic        trigger_clocked_input;
  logic [9:0]  conv_code;
  logic        port_access_enable;
  logic        port_write_enable;
  logic [6:0]  port_addr_bus;
  logic [15:0] port_write_bus;
  logic [15:0] port_read_bus;
  logic        port_access_done;
  logic        busy;
  logic        conv_done_pulse;
  logic        sequence_done_pulse;
  logic [4:0]  channel;
  int          n_errors;
  int          n_compared;
  int          n_eoc;
  int          n;
  logic [15:0] q;
  esa_row_t    rows [9] = '{
    '{1'b0, ADDR_SEQ_MASK, 16'h0000, SEQ_MASK_RST}, '{1'b0, ADDR_CFG2, 16'h0000, CFG2_RST},
    '{1'b0, ADDR_CFG1, 16'h0000, CFG1_RST}, '{1'b1, ADDR_CFG2, 16'h0400, 16'h0000},
    '{1'b0, ADDR_CFG2, 16'h0000, 16'h0400}, '{1'b1, 7'h7F, 16'hBEEF, 16'h0000},
    '{1'b0, 7'h7F, 16'h0000, 16'h0000}, '{1'b1, 7'h05, 16'h1234, 16'h0000},
    '{1'b0, 7'h05, 16'h0000, 16'h0000}};

  esa_ctrl esa_ctrl_inst (.clk(clk), .rst_b(rst_b), .trigger_level_input(trigger_level_input),
    .trigger_clocked_input(trigger_clocked_input), .conv_code(conv_code),
    .port_access_enable(port_access_enable), .port_write_enable(port_write_enable),
    .port_addr_bus(port_addr_bus), .port_write_bus(port_write_bus),
    .port_read_bus(port_read_bus), .port_access_done(port_access_done), .busy(busy),
    .conv_done_pulse(conv_done_pulse), .sequence_done_pulse(sequence_done_pulse),
    .channel(channel));

  esa_trig_src esa_trig_src_inst (.clk(clk), .fire(fire), .sel(sel), .code(code),
    .trigger_level_input(trigger_level_input), .trigger_clocked_input(trigger_clocked_input),
    .conv_code(conv_code));

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  always @(posedge clk)
    if (conv_done_pulse === 1'b1)
      n_eoc++;

  task end_of_test;
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : end_of_test

  task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e)
    begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task chk_i(input string nm, input int e, input int g);
    n_compared++;
    if (g != e)
    begin
      n_errors++;
      $display("MISMATCH %s expected %0d seen %0d", nm, e, g);
    end
  endtask : chk_i

  // Bounded wait for busy (s=0) or end of conversion (s=1) to reach v
  task wt(input logic s, input logic v, input int lim, output int c);
    c = 0;
    while ((s ? conv_done_pulse : busy) !== v)
    begin
      @(posedge clk);
      #1;
      c++;
      if (c > lim)
      begin
        n_errors++;
        $display("MISMATCH wait %0d expected %0b seen timeout", s, v);
        end_of_test;
      end
    end
  endtask : wt

  task acc(input logic w, input logic [6:0] a, input logic [15:0] d, output logic [15:0] r);
    int i;
    i = 0;
    @(posedge clk);
    port_access_enable <= 1'b1;
    port_write_enable  <= w;
    port_addr_bus      <= a;
    port_write_bus     <= d;
    @(posedge clk);
    port_access_enable <= 1'b0;
    while (port_access_done !== 1'b1 && i < 8)
    begin
      @(posedge clk);
      #1;
      i++;
    end
    chk_i("port latency", 3, i);
    if (i >= 8)
      end_of_test;
    r = port_read_bus;
  endtask : acc

  task trig(input logic s);
    @(posedge clk);
    fire <= 1'b1;
    sel  <= s;
    @(posedge clk);
    fire <= 1'b0;
  endtask : trig

  // One triggered conversion, with a config write and a lost retrigger while busy
  task conv(input logic s, input logic [9:0] cd, input logic [15:0] cfg,
            input logic [4:0] ch, input logic [15:0] res);
    code <= cd;
    repeat (20) @(posedge clk);
    trig(s);
    wt(1'b0, 1'b1, 10, n);
    chk_i("trigger to busy", 1, n);
    acc(1'b1, ADDR_CFG0, cfg, q);
    trig(!s);
    wt(1'b0, 1'b0, 400, n);
    chk("channel", {11'h000, ch}, {11'h000, channel});
    wt(1'b1, 1'b1, 20, n);
    chk_i("busy fall to end", 10, n);
    acc(1'b0, {2'b00, ch}, 16'h0000, q);
    chk("result", res, q);
  endtask : conv

  initial
  begin
    n_errors = 0;
    n_compared = 0;
    n_eoc = 0;
    rst_b = 1'b0;
    fire = 1'b0;
    sel = 1'b0;
    code = 10'h000;
    port_access_enable = 1'b0;
    port_write_enable = 1'b0;
    port_addr_bus = 7'h00;
    port_write_bus = 16'h0000;
    repeat (15) @(posedge clk);
    #1;
    chk("reset outputs", 16'h0000, {7'h00, port_access_done, busy, conv_done_pulse,
        sequence_done_pulse, channel});
    @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    foreach (rows[i])
    begin
      acc(rows[i].w, rows[i].a, rows[i].d, q);
      if (!rows[i].w)
        chk("read data", rows[i].e, q);
    end
    // Event mode takes hold only when the running conversion ends
    wt(1'b0, 1'b1, 100, n);
    acc(1'b1, ADDR_CFG0, 16'h0203, q);
    wt(1'b0, 1'b0, 400, n);
    repeat (100) @(posedge clk);
    chk("idle busy", 16'h0000, {15'h0000, busy});
    conv(1'b0, 10'h2AB, 16'h0305, 5'h03, 16'hAAC0);
    conv(1'b1, 10'h155, 16'h0205, 5'h05, 16'h5540);
    // A write after the fall waits for one more trigger
    acc(1'b1, ADDR_CFG0, 16'h0000, q);
    repeat (100) @(posedge clk);
    chk("late write idle", 16'h0000, {15'h0000, busy});
    trig(1'b0);
    wt(1'b0, 1'b1, 10, n);
    wt(1'b0, 1'b0, 400, n);
    wt(1'b0, 1'b1, 60, n);
    acc(1'b1, ADDR_CFG0, 16'h1000, q);
    wt(1'b0, 1'b0, 400, n);
    repeat (12) @(posedge clk);
    n_eoc = 0;
    repeat (16)
    begin
      wt(1'b0, 1'b1, 100, n);
      wt(1'b0, 1'b0, 400, n);
    end
    repeat (12) @(posedge clk);
    chk_i("averaged pulses", 1, n_eoc);
    // Sequencer overrides the event bit; sequence end only on the last channel
    wt(1'b0, 1'b1, 100, n);
    acc(1'b1, ADDR_CFG0, 16'h0200, q);
    acc(1'b1, ADDR_CFG1, 16'h1000, q);
    acc(1'b1, ADDR_SEQ_MASK, 16'h0003, q);
    wt(1'b0, 1'b0, 400, n);
    for (int k = 1; k >= 0; k--)
    begin
      wt(1'b0, 1'b1, 60, n);
      wt(1'b0, 1'b0, 400, n);
      chk("sequence channel", 16'(k), {11'h000, channel});
      wt(1'b1, 1'b1, 20, n);
      chk("sequence end", 16'(k), {15'h0000, sequence_done_pulse});
    end
    end_of_test;
  end
endmodule : esa_ctrl_tb

bind esa_ctrl esa_ctrl_chk esa_ctrl_chk_inst (.clk(clk), .rst_b(rst_b),
  .port_access_enable(port_access_enable), .port_access_done(port_access_done), .busy(busy),
  .conv_done_pulse(conv_done_pulse), .sequence_done_pulse(sequence_done_pulse),
  .channel(channel));

// ===== sim/esa_trig_src.sv
// Trigger source and analog core stand-in facing the control block
`timescale 1ns/10ps
module esa_trig_src
(
  input  wire logic       clk,
  input  wire logic       fire,
  input  wire logic       sel,
  input  wire logic [9:0] code,
  output logic            trigger_level_input,
  output logic            trigger_clocked_input,
  output logic      [9:0] conv_code
);
  logic [2:0] hold_ff;

  initial
  begin
    trigger_level_input   = 1'b0;
    trigger_clocked_input = 1'b0;
    hold_ff               = 3'h0;
  end

  assign conv_code = code;

  // Level input lands off the clock edge, as a truly asynchronous source would
  always @(posedge clk)
  begin
    if (fire)
    begin
      trigger_level_input   <= #7 !sel;
      trigger_clocked_input <= sel;
      hold_ff               <= 3'h4;
    end
    else if (hold_ff != 3'h0)
    begin
      hold_ff <= hold_ff - 3'h1;
      if (hold_ff == 3'h1)
      begin
        trigger_level_input   <= #7 1'b0;
        trigger_clocked_input <= 1'b0;
      end
    end
  end
endmodule : esa_trig_src
